// File: rtl/adc_ctl_pkg.sv
package adc_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] CHAN_SEL_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] PAIR_CFG_ADDR = 8'h0C;
  localparam logic [ADDR_W-1:0] PORT_SEL_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] RESULT_ADDR = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Control register bit positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam int CTRL_BUSY_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths and reset values
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 4;
  localparam int PAIR_W = 4;
  localparam int PORT_W = 8;
  localparam int GAIN_W = 3;
  localparam int CHAN_TEMP_BIT = 3;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;
  localparam logic [PAIR_W-1:0] PAIR_RESET = 4'h0;
  localparam logic [PORT_W-1:0] PORT_RESET = 8'h00;
  localparam logic [PORT_W-1:0] EVEN_PIN_MASK = 8'h55;
  localparam logic [PORT_W-1:0] ODD_PIN_MASK = 8'hAA;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Gain codes
  localparam logic [GAIN_W-1:0] GAIN_X1 = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_X2 = 3'h1;
  localparam logic [GAIN_W-1:0] GAIN_X4 = 3'h2;
  localparam logic [GAIN_W-1:0] GAIN_X8 = 3'h3;
  localparam logic [GAIN_W-1:0] GAIN_X16 = 3'h4;
  localparam logic [GAIN_W-1:0] GAIN_X0P5 = 3'h6;
  localparam logic [GAIN_W-1:0] GAIN_RESET = GAIN_X1;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_TIME_NS = 500;
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRACK_TICKS = 8;
  localparam int CONV_CYCLES = (TRACK_TICKS + RESULT_W) * BIT_CYCLES;
  localparam int TICK_W = 5;
  localparam int STEP_W = 4;
  localparam int AGE_W = 10;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BIT_CYCLES - 1);
  localparam logic [STEP_W-1:0] TRACK_LAST = STEP_W'(TRACK_TICKS - 1);
  localparam logic [AGE_W-1:0] DONE_AGE = AGE_W'(CONV_CYCLES + 1);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_TRACK, SEQ_CONVERT} seq_state_e;

endpackage

// File: rtl/sar_sequencer.sv
`timescale 1ns/1ns
module sar_sequencer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic comp_i,
  // Status and result
  output logic busy_o,
  output logic sample_o,
  output logic done_o,
  output logic [adc_ctl_pkg::RESULT_W-1:0] trial_o,
  output logic [adc_ctl_pkg::RESULT_W-1:0] result_o
);

  adc_ctl_pkg::seq_state_e state_reg, state_next;
  logic [adc_ctl_pkg::TICK_W-1:0] tick_reg, tick_next;
  logic [adc_ctl_pkg::STEP_W-1:0] step_reg, step_next;
  logic [adc_ctl_pkg::RESULT_W-1:0] trial_reg, trial_next;
  logic [adc_ctl_pkg::RESULT_W-1:0] bit_reg, bit_next;
  logic [adc_ctl_pkg::RESULT_W-1:0] result_reg, result_next;
  logic done_reg, done_next;
  logic tick;
  logic [adc_ctl_pkg::RESULT_W-1:0] kept;

  ////////////////////////////////////////////////////////////////////////////
  // Bit-time divider and successive approximation
  assign tick = (tick_reg == adc_ctl_pkg::TICK_LAST);
  assign kept = comp_i ? trial_reg : (trial_reg & ~bit_reg);

  always_comb
  begin
    state_next = state_reg;
    tick_next = tick ? '0 : tick_reg + 1'b1;
    step_next = step_reg;
    trial_next = trial_reg;
    bit_next = bit_reg;
    result_next = result_reg;
    done_next = 1'b0;
    case (state_reg)
      adc_ctl_pkg::SEQ_IDLE:
      begin
        tick_next = '0;
        if (start_i && enable_i)
        begin
          state_next = adc_ctl_pkg::SEQ_TRACK;
          step_next = '0;
        end
      end
      adc_ctl_pkg::SEQ_TRACK:
      begin
        if (tick)
        begin
          step_next = step_reg + 1'b1;
          if (step_reg == adc_ctl_pkg::TRACK_LAST)
          begin
            state_next = adc_ctl_pkg::SEQ_CONVERT;
            bit_next = {1'b1, {(adc_ctl_pkg::RESULT_W-1){1'b0}}};
            trial_next = {1'b1, {(adc_ctl_pkg::RESULT_W-1){1'b0}}};
          end
        end
      end
      adc_ctl_pkg::SEQ_CONVERT:
      begin
        if (tick)
        begin
          bit_next = bit_reg >> 1;
          trial_next = kept | (bit_reg >> 1);
          if (bit_reg[0])
          begin
            state_next = adc_ctl_pkg::SEQ_IDLE;
            result_next = kept;
            done_next = 1'b1;
          end
        end
      end
      default:
      begin
        state_next = adc_ctl_pkg::SEQ_IDLE;
      end
    endcase
    if (!enable_i)
    begin
      state_next = adc_ctl_pkg::SEQ_IDLE;
      result_next = result_reg;
      done_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= adc_ctl_pkg::SEQ_IDLE;
      tick_reg <= '0;
      step_reg <= '0;
      trial_reg <= adc_ctl_pkg::RESULT_RESET;
      bit_reg <= adc_ctl_pkg::RESULT_RESET;
      result_reg <= adc_ctl_pkg::RESULT_RESET;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      step_reg <= step_next;
      trial_reg <= trial_next;
      bit_reg <= bit_next;
      result_reg <= result_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = (state_reg != adc_ctl_pkg::SEQ_IDLE);
  assign sample_o = (state_reg == adc_ctl_pkg::SEQ_TRACK);
  assign done_o = done_reg;
  assign trial_o = trial_reg;
  assign result_o = result_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [adc_ctl_pkg::AGE_W-1:0] age_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      age_reg <= '0;
    end
    else if (!busy_o && start_i && enable_i)
    begin
      age_reg <= adc_ctl_pkg::AGE_W'(1);
    end
    else if (busy_o)
    begin
      age_reg <= age_reg + 1'b1;
    end
  end

  a_done_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |-> age_reg == adc_ctl_pkg::DONE_AGE)
    else $error("conversion did not last the expected cycles");

  a_start_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (!busy_o && !enable_i) |=> !busy_o)
    else $error("conversion started while disabled");

  a_result_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable_i |=> $stable(result_o))
    else $error("result changed while disabled");

endmodule // sar_sequencer

// File: rtl/adc_mux_gain_control.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Converter, track-and-hold and amplifier powered only while enable bit is one.
// - Enable bit zero drops power and holds the sequencer idle; mux, port and gain routing still follow their registers.
// - Multiplexer offers external inputs, port even/odd, high-voltage amp, temperature.
// - Each input pair is set single-ended or differential by software.
// - Pair configuration may change at run time between conversions.
// - Every input pair is single-ended after reset.
// - Three multiplexer registers: channel select, pair config, port-pin select.
// - Amplifier gain comes from the three-bit gain code field.
// - Gain codes select 0.5, 1, 2, 4, 8 and 16.
// - Reset loads the gain code for unity gain.
// - Twelve-bit successive approximation results, at most 100 ksps.
// - Any port pins selectable; even pins and odd pins feed separate inputs.
module adc_mux_gain_control
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [adc_ctl_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [adc_ctl_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [adc_ctl_pkg::DATA_W-1:0] wb_dat_i,
  output logic [adc_ctl_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog front end
  input wire logic comp_i,
  output logic power_o,
  output logic sample_o,
  output logic [adc_ctl_pkg::RESULT_W-1:0] trial_o,
  output logic [adc_ctl_pkg::CHAN_W-1:0] mux_chan_o,
  output logic mux_diff_o,
  output logic [adc_ctl_pkg::PAIR_W-1:0] pair_diff_o,
  output logic [adc_ctl_pkg::PORT_W-1:0] port_pins_o,
  output logic port_even_o,
  output logic port_odd_o,
  output logic [adc_ctl_pkg::GAIN_W-1:0] gain_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic enable_reg, enable_next;
  logic start_reg, start_next;
  logic done_flag_reg, done_flag_next;
  logic [adc_ctl_pkg::GAIN_W-1:0] gain_reg, gain_next;
  logic [adc_ctl_pkg::CHAN_W-1:0] chan_reg, chan_next;
  logic [adc_ctl_pkg::PAIR_W-1:0] pair_reg, pair_next;
  logic [adc_ctl_pkg::PORT_W-1:0] port_reg, port_next;
  logic ack_reg, ack_next;
  logic [adc_ctl_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic req;
  logic wr;
  logic busy;
  logic done;
  logic [adc_ctl_pkg::RESULT_W-1:0] result;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[0];

  always_comb
  begin
    enable_next = enable_reg;
    start_next = 1'b0;
    done_flag_next = done_flag_reg;
    gain_next = gain_reg;
    chan_next = chan_reg;
    pair_next = pair_reg;
    port_next = port_reg;
    rdata_next = rdata_reg;
    ack_next = req;
    if (wr)
    begin
      if (wb_adr_i == adc_ctl_pkg::CONTROL_ADDR)
      begin
        enable_next = wb_dat_i[adc_ctl_pkg::CTRL_ENABLE_BIT];
        start_next = wb_dat_i[adc_ctl_pkg::CTRL_START_BIT];
        if (wb_dat_i[adc_ctl_pkg::CTRL_DONE_BIT])
        begin
          done_flag_next = 1'b0;
        end
      end
      else if (wb_adr_i == adc_ctl_pkg::CONFIG_ADDR)
      begin
        gain_next = wb_dat_i[adc_ctl_pkg::GAIN_W-1:0];
      end
      else if (wb_adr_i == adc_ctl_pkg::CHAN_SEL_ADDR)
      begin
        chan_next = wb_dat_i[adc_ctl_pkg::CHAN_W-1:0];
      end
      else if (wb_adr_i == adc_ctl_pkg::PAIR_CFG_ADDR)
      begin
        pair_next = wb_dat_i[adc_ctl_pkg::PAIR_W-1:0];
      end
      else if (wb_adr_i == adc_ctl_pkg::PORT_SEL_ADDR)
      begin
        port_next = wb_dat_i[adc_ctl_pkg::PORT_W-1:0];
      end
    end
    if (done)
    begin
      done_flag_next = 1'b1;
    end
    if (req && !wb_we_i)
    begin
      rdata_next = '0;
      if (wb_adr_i == adc_ctl_pkg::CONTROL_ADDR)
      begin
        rdata_next[adc_ctl_pkg::CTRL_ENABLE_BIT] = enable_reg;
        rdata_next[adc_ctl_pkg::CTRL_DONE_BIT] = done_flag_reg;
        rdata_next[adc_ctl_pkg::CTRL_BUSY_BIT] = busy;
      end
      else if (wb_adr_i == adc_ctl_pkg::CONFIG_ADDR)
      begin
        rdata_next[adc_ctl_pkg::GAIN_W-1:0] = gain_reg;
      end
      else if (wb_adr_i == adc_ctl_pkg::CHAN_SEL_ADDR)
      begin
        rdata_next[adc_ctl_pkg::CHAN_W-1:0] = chan_reg;
      end
      else if (wb_adr_i == adc_ctl_pkg::PAIR_CFG_ADDR)
      begin
        rdata_next[adc_ctl_pkg::PAIR_W-1:0] = pair_reg;
      end
      else if (wb_adr_i == adc_ctl_pkg::PORT_SEL_ADDR)
      begin
        rdata_next[adc_ctl_pkg::PORT_W-1:0] = port_reg;
      end
      else if (wb_adr_i == adc_ctl_pkg::RESULT_ADDR)
      begin
        rdata_next[adc_ctl_pkg::RESULT_W-1:0] = result;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_reg <= 1'b0;
      start_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      gain_reg <= adc_ctl_pkg::GAIN_RESET;
      chan_reg <= adc_ctl_pkg::CHAN_RESET;
      pair_reg <= adc_ctl_pkg::PAIR_RESET;
      port_reg <= adc_ctl_pkg::PORT_RESET;
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      enable_reg <= enable_next;
      start_reg <= start_next;
      done_flag_reg <= done_flag_next;
      gain_reg <= gain_next;
      chan_reg <= chan_next;
      pair_reg <= pair_next;
      port_reg <= port_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser
  logic comp_meta_reg, comp_sync_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end
    else
    begin
      comp_meta_reg <= comp_i;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  sar_sequencer sar_sequencer_inst
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(enable_reg),
    .start_i(start_reg),
    .comp_i(comp_sync_reg),
    .busy_o(busy),
    .sample_o(sample_o),
    .done_o(done),
    .trial_o(trial_o),
    .result_o(result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Front-end routing, frozen while a conversion runs
  logic [adc_ctl_pkg::CHAN_W-1:0] mux_chan_reg, mux_chan_next;
  logic mux_diff_reg, mux_diff_next;
  logic [adc_ctl_pkg::PAIR_W-1:0] pair_out_reg, pair_out_next;
  logic [adc_ctl_pkg::PORT_W-1:0] port_out_reg, port_out_next;
  logic port_even_reg, port_even_next;
  logic port_odd_reg, port_odd_next;
  logic [adc_ctl_pkg::GAIN_W-1:0] gain_out_reg, gain_out_next;
  logic power_reg, power_next;

  always_comb
  begin
    mux_chan_next = mux_chan_reg;
    mux_diff_next = mux_diff_reg;
    pair_out_next = pair_out_reg;
    port_out_next = port_out_reg;
    port_even_next = port_even_reg;
    port_odd_next = port_odd_reg;
    gain_out_next = gain_out_reg;
    power_next = enable_reg;
    if (!busy)
    begin
      mux_diff_next = !chan_reg[adc_ctl_pkg::CHAN_TEMP_BIT]
        && pair_reg[chan_reg[2:1]];
      mux_chan_next = mux_diff_next ? {chan_reg[3:1], 1'b0} : chan_reg;
      pair_out_next = pair_reg;
      port_out_next = port_reg;
      port_even_next = |(port_reg & adc_ctl_pkg::EVEN_PIN_MASK);
      port_odd_next = |(port_reg & adc_ctl_pkg::ODD_PIN_MASK);
      gain_out_next = gain_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mux_chan_reg <= adc_ctl_pkg::CHAN_RESET;
      mux_diff_reg <= 1'b0;
      pair_out_reg <= adc_ctl_pkg::PAIR_RESET;
      port_out_reg <= adc_ctl_pkg::PORT_RESET;
      port_even_reg <= 1'b0;
      port_odd_reg <= 1'b0;
      gain_out_reg <= adc_ctl_pkg::GAIN_RESET;
      power_reg <= 1'b0;
    end
    else
    begin
      mux_chan_reg <= mux_chan_next;
      mux_diff_reg <= mux_diff_next;
      pair_out_reg <= pair_out_next;
      port_out_reg <= port_out_next;
      port_even_reg <= port_even_next;
      port_odd_reg <= port_odd_next;
      gain_out_reg <= gain_out_next;
      power_reg <= power_next;
    end
  end

  assign mux_chan_o = mux_chan_reg;
  assign mux_diff_o = mux_diff_reg;
  assign pair_diff_o = pair_out_reg;
  assign port_pins_o = port_out_reg;
  assign port_even_o = port_even_reg;
  assign port_odd_o = port_odd_reg;
  assign gain_o = gain_out_reg;
  assign power_o = power_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ctrl_write_off;
    wr && wb_adr_i == adc_ctl_pkg::CONTROL_ADDR && !wb_dat_i[adc_ctl_pkg::CTRL_ENABLE_BIT];
  endsequence

  sequence s_power_down;
    ##2 !power_o;
  endsequence

  a_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ctrl_write_off |-> s_power_down)
    else $error("subsystem still powered after disable");

  a_power_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (sample_o || busy) |-> ##1 (power_o || !enable_reg))
    else $error("conversion activity without power");

  a_gain_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> gain_o == adc_ctl_pkg::GAIN_X1 && gain_reg == adc_ctl_pkg::GAIN_X1)
    else $error("gain not unity after reset");

  a_pair_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> pair_diff_o == '0 && !mux_diff_o)
    else $error("input pairs not single-ended after reset");

  a_port_split: assert property (@(posedge clk_i) disable iff (rst_i)
    !busy |=> port_even_o == |($past(port_reg) & adc_ctl_pkg::EVEN_PIN_MASK)
      && port_odd_o == |($past(port_reg) & adc_ctl_pkg::ODD_PIN_MASK))
    else $error("even or odd port input wrong");

  a_route_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy && $past(busy)) |-> $stable(mux_chan_o) && $stable(gain_o))
    else $error("routing changed during a conversion");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");

endmodule // adc_mux_gain_control

// File: verif/adc_mux_gain_control_tb.sv
`timescale 1ns/1ns
module adc_mux_gain_control_tb;
  ////////////////////////////////////////////////////////////////////////////
  // Signals
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [adc_ctl_pkg::ADDR_W-1:0] wb_adr_i;
  logic [adc_ctl_pkg::SEL_W-1:0] wb_sel_i;
  logic [adc_ctl_pkg::DATA_W-1:0] wb_dat_i;
  logic [adc_ctl_pkg::DATA_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic comp_i;
  logic power_o;
  logic sample_o;
  logic [adc_ctl_pkg::RESULT_W-1:0] trial_o;
  logic [adc_ctl_pkg::CHAN_W-1:0] mux_chan_o;
  logic mux_diff_o;
  logic [adc_ctl_pkg::PAIR_W-1:0] pair_diff_o;
  logic [adc_ctl_pkg::PORT_W-1:0] port_pins_o;
  logic port_even_o;
  logic port_odd_o;
  logic [adc_ctl_pkg::GAIN_W-1:0] gain_o;
  logic [31:0] rd;
  int errors;
  int checks_done;

  adc_mux_gain_control adc_mux_gain_control_inst
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .comp_i(comp_i),
    .power_o(power_o),
    .sample_o(sample_o),
    .trial_o(trial_o),
    .mux_chan_o(mux_chan_o),
    .mux_diff_o(mux_diff_o),
    .pair_diff_o(pair_diff_o),
    .port_pins_o(port_pins_o),
    .port_even_o(port_even_o),
    .port_odd_o(port_odd_o),
    .gain_o(gain_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      check(32'h0, 32'h1);
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb(1'b1, adr, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hF);
    check(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      wb(1'b0, adc_ctl_pkg::CONTROL_ADDR, 32'h0, 4'hF);
      n++;
    end
    while (rd[adc_ctl_pkg::CTRL_DONE_BIT] !== 1'b1 && n < 30);
    check(32'(rd[adc_ctl_pkg::CTRL_DONE_BIT]), 32'h1);
    if (rd[adc_ctl_pkg::CTRL_DONE_BIT] !== 1'b1)
      summarize();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd_chk(adc_ctl_pkg::CONTROL_ADDR, 32'h0);
    rd_chk(adc_ctl_pkg::CONFIG_ADDR, 32'(adc_ctl_pkg::GAIN_RESET));
    rd_chk(adc_ctl_pkg::CHAN_SEL_ADDR, 32'h0);
    rd_chk(adc_ctl_pkg::PAIR_CFG_ADDR, 32'h0);
    rd_chk(adc_ctl_pkg::PORT_SEL_ADDR, 32'h0);
    rd_chk(adc_ctl_pkg::RESULT_ADDR, 32'h0);
    rd_chk(8'h20, 32'h0);
    check(32'(power_o), 32'h0);
    check(32'(gain_o), 32'(adc_ctl_pkg::GAIN_X1));
    check(32'(pair_diff_o), 32'h0);
  endtask

  task automatic t_enable();
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h1);
    idle(3);
    check(32'(power_o), 32'h1);
    rd_chk(adc_ctl_pkg::CONTROL_ADDR, 32'h1);
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h0);
    idle(3);
    check(32'(power_o), 32'h0);
  endtask

  task automatic t_gain();
    logic [2:0] codes[6];
    codes = '{adc_ctl_pkg::GAIN_X1, adc_ctl_pkg::GAIN_X2, adc_ctl_pkg::GAIN_X4,
              adc_ctl_pkg::GAIN_X8, adc_ctl_pkg::GAIN_X16, adc_ctl_pkg::GAIN_X0P5};
    foreach (codes[i])
    begin
      wr(adc_ctl_pkg::CONFIG_ADDR, 32'(codes[i]));
      rd_chk(adc_ctl_pkg::CONFIG_ADDR, 32'(codes[i]));
      idle(2);
      check(32'(gain_o), 32'(codes[i]));
    end
    // Low byte lane off: write dropped
    wb(1'b1, adc_ctl_pkg::CONFIG_ADDR, 32'(adc_ctl_pkg::GAIN_X2), 4'hE);
    idle(2);
    check(32'(gain_o), 32'(adc_ctl_pkg::GAIN_X0P5));
  endtask

  task automatic t_mux();
    logic [3:0] p;
    logic dif;
    logic [7:0] pins[5];
    pins = '{8'h01, 8'h02, 8'hFF, 8'h00, 8'h50};
    for (int k = 0; k < 2; k++)
    begin
      p = (k == 0) ? 4'h0 : 4'hF;
      wr(adc_ctl_pkg::PAIR_CFG_ADDR, 32'(p));
      rd_chk(adc_ctl_pkg::PAIR_CFG_ADDR, 32'(p));
      for (int c = 0; c < 9; c++)
      begin
        wr(adc_ctl_pkg::CHAN_SEL_ADDR, 32'(c));
        idle(2);
        dif = (c < 8) && p[c / 2];
        check(32'(mux_chan_o), dif ? 32'(c & 6) : 32'(c));
        check(32'(mux_diff_o), 32'(dif));
        check(32'(pair_diff_o), 32'(p));
      end
    end
    foreach (pins[i])
    begin
      wr(adc_ctl_pkg::PORT_SEL_ADDR, 32'(pins[i]));
      idle(2);
      check(32'(port_pins_o), 32'(pins[i]));
      check(32'(port_even_o), 32'(|(pins[i] & adc_ctl_pkg::EVEN_PIN_MASK)));
      check(32'(port_odd_o), 32'(|(pins[i] & adc_ctl_pkg::ODD_PIN_MASK)));
    end
  endtask

  task automatic t_convert();
    comp_i <= 1'b1;
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h3);
    idle(10);
    check(32'(sample_o), 32'h1);
    idle(210);
    check(32'(sample_o), 32'h0);
    check(32'(trial_o), 32'h00000800);
    idle(260);
    wb(1'b0, adc_ctl_pkg::CONTROL_ADDR, 32'h0, 4'hF);
    check(32'(rd[adc_ctl_pkg::CTRL_BUSY_BIT]), 32'h1);
    wait_done();
    rd_chk(adc_ctl_pkg::RESULT_ADDR, 32'h00000FFF);
    check(32'(trial_o), 32'h00000FFF);
    // Pair setting changed between conversions, still powered
    wr(adc_ctl_pkg::PAIR_CFG_ADDR, 32'h1);
    idle(2);
    check(32'(pair_diff_o), 32'h1);
    check(32'(power_o), 32'h1);
    // Start a conversion with enable and start set, clearing the done flag
    comp_i <= 1'b0;
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h7);
    idle(50);
    // Gain written mid-conversion waits for idle
    wr(adc_ctl_pkg::CONFIG_ADDR, 32'(adc_ctl_pkg::GAIN_X2));
    idle(2);
    check(32'(gain_o), 32'(adc_ctl_pkg::GAIN_X0P5));
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h0);
    idle(3);
    check(32'(power_o), 32'h0);
    check(32'(gain_o), 32'(adc_ctl_pkg::GAIN_X2));
    rd_chk(adc_ctl_pkg::RESULT_ADDR, 32'h00000FFF);
    // Start while disabled is ignored
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h2);
    idle(10);
    wb(1'b0, adc_ctl_pkg::CONTROL_ADDR, 32'h0, 4'hF);
    check(32'(rd[adc_ctl_pkg::CTRL_BUSY_BIT]), 32'h0);
    rd_chk(adc_ctl_pkg::RESULT_ADDR, 32'h00000FFF);
    // Full conversion with comparator low
    wr(adc_ctl_pkg::CONTROL_ADDR, 32'h3);
    idle(480);
    wait_done();
    rd_chk(adc_ctl_pkg::RESULT_ADDR, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    errors = 0;
    checks_done = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    comp_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_enable();
    t_gain();
    t_mux();
    t_convert();
    summarize();
  end
endmodule // adc_mux_gain_control_tb
